// *** sdst_core.sv ***
// Stall detection and stop-on-stall with Wishbone register access.
// Assumes raw load samples and step toggles from the power stage logic,
// both asynchronous; ramp velocity comes from the same clock domain.
`timescale 1ns/1ps
module sdst_core (
   input  wire logic                           clk_sys,
   input  wire logic                           arst_n,
   input  wire logic [7:0]                     wb_adr_i,
   input  wire logic [31:0]                    wb_dat_i,
   input  wire logic [3:0]                     wb_sel_i,
   input  wire logic                           wb_we_i,
   input  wire logic                           wb_cyc_i,
   input  wire logic                           wb_stb_i,
   output logic      [31:0]                    wb_dat_o,
   output logic                                wb_ack_o,
   input  wire logic                           fullstep_tgl,
   input  wire logic [sdst_pkg::LOAD_W-1:0]    raw_load,
   input  wire logic [31:0]                    ramp_velocity,
   output logic      [31:0]                    actual_velocity,
   output logic                                ramp_halt,
   output logic                                irq
);
   logic                              stp_s1_r, stp_s2_r, stp_s3_r;
   logic [1:0]                        stp_warm_r;
   logic [sdst_pkg::LOAD_W-1:0]       ld_s1_r, ld_s2_r;
   logic                              step_p;
   logic [sdst_pkg::LOAD_W-1:0]       adj_load;
   logic                              flt_vld;
   logic [sdst_pkg::LOAD_W-1:0]       flt_load;
   logic [sdst_pkg::LOAD_W-1:0]       load_reading_r;
   logic                              stop_on_stall_enable_r;
   logic                              filt_en_r;
   logic [sdst_pkg::THR_W-1:0]        stall_threshold_offset_r;
   logic [sdst_pkg::PER_W-1:0]        lower_velocity_limit_r;
   logic [sdst_pkg::PER_W-1:0]        upper_velocity_limit_r;
   logic [sdst_pkg::ZW_W-1:0]         zero_wait_time_r;
   logic [sdst_pkg::PER_W-1:0]        step_period_measure_r;
   logic [sdst_pkg::PER_W-1:0]        per_cnt_r;
   logic                              stall_stop_event_r;
   logic [sdst_pkg::IRQ_W-1:0]        irq_stat_r, irq_en_r;
   logic [sdst_pkg::ZW_W-1:0]         zw_cnt_r;
   logic [sdst_pkg::ZW_PRE_W-1:0]     zw_pre_r;
   sdst_pkg::sdst_state_t             st_r, st_nxt;
   logic                              wr_acc, rd_acc, in_window, stall_det, rd_ramp;
   logic [31:0]                       rd_nxt;

   // Synchronise asynchronous step toggle and load samples
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stp_s1_r <= 1'b0;
         stp_s2_r <= 1'b0;
         stp_s3_r <= 1'b0;
         stp_warm_r <= 2'h0;
         ld_s1_r  <= '0;
         ld_s2_r  <= '0;
      end else begin
         stp_s1_r <= fullstep_tgl;
         stp_s2_r <= stp_s1_r;
         stp_s3_r <= stp_s2_r;
         if (stp_warm_r != 2'h3)
            stp_warm_r <= stp_warm_r + 2'h1;
         ld_s1_r  <= raw_load;
         ld_s2_r  <= ld_s1_r;
      end
   end
   // Mask the false edge while the chain refills after reset
   assign step_p = (stp_s2_r ^ stp_s3_r) && (stp_warm_r == 2'h3);

   function automatic logic [sdst_pkg::LOAD_W-1:0] apply_offset(
      input logic [sdst_pkg::LOAD_W-1:0] ld,
      input logic [sdst_pkg::THR_W-1:0]  off);
      logic signed [sdst_pkg::LOAD_W+1:0] s;
      s = $signed({2'b00, ld}) + {{(sdst_pkg::LOAD_W+2-sdst_pkg::THR_W){off[6]}}, off};
      if (s < 0)
         apply_offset = '0;
      else if (s > $signed(12'h3ff))
         apply_offset = 10'h3ff;
      else
         apply_offset = s[sdst_pkg::LOAD_W-1:0];
   endfunction : apply_offset

   assign adj_load = apply_offset(ld_s2_r, stall_threshold_offset_r);

   sdst_filter u_filter (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .smp_vld  (step_p),
      .smp      (adj_load),
      .filt_en  (filt_en_r),
      .out_vld  (flt_vld),
      .out_load (flt_load)
   );

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         load_reading_r <= 10'h3ff;
      else if (flt_vld)
         load_reading_r <= flt_load;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         per_cnt_r             <= '0;
         step_period_measure_r <= '1;
      end else if (step_p) begin
         step_period_measure_r <= per_cnt_r;
         per_cnt_r             <= '0;
      end else if (per_cnt_r != '1) begin
         per_cnt_r <= per_cnt_r + 20'h00001;
      end else begin
         step_period_measure_r <= '1;
      end
   end

   assign in_window = (step_period_measure_r <= lower_velocity_limit_r)
                    && (step_period_measure_r >= upper_velocity_limit_r);
   assign stall_det = stop_on_stall_enable_r && in_window && flt_vld
                    && (flt_load == '0) && (st_r == sdst_pkg::SDST_RUN);

   // Writes and read side effects land on the edge that sees ack
   assign wr_acc  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign rd_acc  = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
   assign rd_ramp = rd_acc && (wb_adr_i == sdst_pkg::ADR_RAMP_STAT);

   // Configuration writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stop_on_stall_enable_r   <= 1'b0;
         filt_en_r                <= 1'b0;
         stall_threshold_offset_r <= sdst_pkg::RST_THRESH;
         lower_velocity_limit_r   <= sdst_pkg::RST_LOW_LIM;
         upper_velocity_limit_r   <= sdst_pkg::RST_UP_LIM;
         zero_wait_time_r         <= sdst_pkg::RST_ZWAIT;
         irq_en_r                 <= '0;
      end else if (wr_acc && wb_sel_i == 4'hf) begin
         unique case (wb_adr_i)
            sdst_pkg::ADR_SWITCH_MODE_WORD: begin
               stop_on_stall_enable_r <= wb_dat_i[sdst_pkg::SWM_STOP_BIT];
               filt_en_r              <= wb_dat_i[sdst_pkg::SWM_FILT_BIT];
            end
            sdst_pkg::ADR_THRESH:  stall_threshold_offset_r <= wb_dat_i[6:0];
            sdst_pkg::ADR_LOW_LIM: lower_velocity_limit_r   <= wb_dat_i[19:0];
            sdst_pkg::ADR_UP_LIM:  upper_velocity_limit_r   <= wb_dat_i[19:0];
            sdst_pkg::ADR_ZWAIT:   zero_wait_time_r         <= wb_dat_i[15:0];
            sdst_pkg::ADR_IRQ_EN:  irq_en_r                 <= wb_dat_i[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         stall_stop_event_r <= 1'b0;
      else if (stall_det)
         stall_stop_event_r <= 1'b1;
      else if (rd_ramp || !stop_on_stall_enable_r)
         stall_stop_event_r <= 1'b0;
   end

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         sdst_pkg::SDST_RUN:  if (stall_det) st_nxt = sdst_pkg::SDST_STOP;
         sdst_pkg::SDST_STOP: begin
            if (!stop_on_stall_enable_r)
               st_nxt = sdst_pkg::SDST_RUN;
            else if (rd_ramp)
               st_nxt = sdst_pkg::SDST_WAIT;
         end
         sdst_pkg::SDST_WAIT: begin
            if (zw_cnt_r == '0 && zw_pre_r == '0)
               st_nxt = sdst_pkg::SDST_RUN;
         end
         default: st_nxt = sdst_pkg::SDST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         st_r <= sdst_pkg::SDST_RUN;
      else
         st_r <= st_nxt;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         zw_cnt_r <= '0;
         zw_pre_r <= '0;
      end else if (st_r != sdst_pkg::SDST_WAIT) begin
         zw_cnt_r <= zero_wait_time_r;
         zw_pre_r <= sdst_pkg::ZW_PRE_W'(sdst_pkg::ZW_UNIT_CYC - 1);
      end else if (zw_pre_r != '0) begin
         zw_pre_r <= zw_pre_r - 9'h001;
      end else if (zw_cnt_r != '0) begin
         zw_cnt_r <= zw_cnt_r - 16'h0001;
         zw_pre_r <= sdst_pkg::ZW_PRE_W'(sdst_pkg::ZW_UNIT_CYC - 1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ramp_halt       <= 1'b0;
         actual_velocity <= '0;
      end else begin
         ramp_halt       <= (st_nxt != sdst_pkg::SDST_RUN);
         actual_velocity <= (st_nxt != sdst_pkg::SDST_RUN) ? 32'h00000000 : ramp_velocity;
      end
   end

   // Sticky interrupt status, set wins over clear
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         irq_stat_r <= '0;
      else begin
         for (int i = 0; i < sdst_pkg::IRQ_W; i++) begin
            if ((i == sdst_pkg::IRQ_STALL_BIT && stall_det)
               || (i == sdst_pkg::IRQ_STEP_BIT && flt_vld))
               irq_stat_r[i] <= 1'b1;
            else if (wr_acc && wb_adr_i == sdst_pkg::ADR_IRQ_CLR && wb_dat_i[i])
               irq_stat_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_r & irq_en_r);
   end

   always_comb begin
      rd_nxt = 32'h00000000;
      unique case (wb_adr_i)
         sdst_pkg::ADR_SWITCH_MODE_WORD: begin
            rd_nxt[sdst_pkg::SWM_STOP_BIT] = stop_on_stall_enable_r;
            rd_nxt[sdst_pkg::SWM_FILT_BIT] = filt_en_r;
         end
         sdst_pkg::ADR_THRESH:  rd_nxt[6:0]  = stall_threshold_offset_r;
         sdst_pkg::ADR_LOW_LIM: rd_nxt[19:0] = lower_velocity_limit_r;
         sdst_pkg::ADR_UP_LIM:  rd_nxt[19:0] = upper_velocity_limit_r;
         sdst_pkg::ADR_ZWAIT:   rd_nxt[15:0] = zero_wait_time_r;
         sdst_pkg::ADR_DRV_STAT: begin
            rd_nxt[9:0]                     = load_reading_r;
            rd_nxt[sdst_pkg::DRV_STALL_BIT] = (st_r != sdst_pkg::SDST_RUN);
         end
         sdst_pkg::ADR_RAMP_STAT: begin
            rd_nxt[sdst_pkg::RS_EVENT_BIT] = stall_stop_event_r;
            rd_nxt[sdst_pkg::RS_VZERO_BIT] = ramp_halt;
            rd_nxt[sdst_pkg::RS_WAIT_BIT]  = (st_r == sdst_pkg::SDST_WAIT);
         end
         sdst_pkg::ADR_IRQ_STAT: rd_nxt[1:0]  = irq_stat_r;
         sdst_pkg::ADR_IRQ_EN:   rd_nxt[1:0]  = irq_en_r;
         sdst_pkg::ADR_PERIOD:   rd_nxt[19:0] = step_period_measure_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // Single-wait ack, read data registered
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= rd_nxt;
      end
   end

   stall_halt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stall_det |=> ramp_halt && actual_velocity == 32'h00000000)
      else $error("No halt after stall");
   stall_event_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stall_det |=> stall_stop_event_r && st_r == sdst_pkg::SDST_STOP)
      else $error("Stall event not set");
   disable_release_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r == sdst_pkg::SDST_STOP && !stop_on_stall_enable_r |=> st_r == sdst_pkg::SDST_RUN)
      else $error("Disable did not release");
   read_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r == sdst_pkg::SDST_STOP && stop_on_stall_enable_r && rd_ramp && !stall_det
         |=> st_r == sdst_pkg::SDST_WAIT && !stall_stop_event_r)
      else $error("Ramp status read ignored");
   window_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !in_window |-> !stall_det)
      else $error("Stall outside window");
   drv_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      st_r != sdst_pkg::SDST_RUN |=> ramp_halt || st_r == sdst_pkg::SDST_RUN)
      else $error("Indicator mismatch");
   step_only_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !filt_en_r && !step_p |=> $stable(flt_load) || !filt_en_r && flt_vld)
      else $error("Reading changed without step");
   load_track_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      flt_vld |=> load_reading_r == $past(flt_load))
      else $error("Load reading not updated");
   // at most one reading per step
   step_once_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      flt_vld |-> $past(step_p))
      else $error("Reading without step");

   sequence zw_done_s;
      st_r == sdst_pkg::SDST_WAIT && zw_cnt_r == '0 && zw_pre_r == '0;
   endsequence
   wait_end_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      zw_done_s |=> st_r == sdst_pkg::SDST_RUN && !ramp_halt)
      else $error("Zero wait did not end");

   // status read keeps halt during wait
   sequence stop_read_s;
      st_r == sdst_pkg::SDST_STOP && stop_on_stall_enable_r && rd_ramp;
   endsequence
   wait_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stop_read_s |=> ramp_halt && !stall_stop_event_r)
      else $error("Wait without halt");

   event_drop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !stop_on_stall_enable_r |=> !stall_stop_event_r)
      else $error("Event kept while disabled");

   // Enabled status raises the interrupt
   irq_level_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (|(irq_stat_r & irq_en_r)) |=> irq)
      else $error("Interrupt not raised");
endmodule : sdst_core

// *** sdst_pkg.sv ***
// Constants of the stall detection and stop-on-stall block.
// Assumes a 40 MHz system clock and a classic Wishbone register bus.
// What this block does
// - Load reading refreshes exactly once per full step when filtering is off.
// - With filter enabled, reading is average of four consecutive step measurements.
// - Threshold offset is signed; lower is more sensitive, higher needs more torque.
// - Stop-on-stall enabled and zero reading cause a stall event and motor stop.
// - On stall stop the ramp halts at once and actual velocity is forced zero.
// - Driver status word shows the stall indicator while a stall stop is active.
// - Reading ramp status clears the stall event; restart follows after zero wait.
// - Clearing stop-on-stall enable releases the stall stop.
// - Detection is suppressed below the lower or above the upper velocity limit.
// - Load reading is ten bits unsigned, zero meaning highest load.
// - Lower velocity limit is compared against the measured step period.
package sdst_pkg;
   localparam int          ADR_W          = 8;
   localparam logic [7:0]  ADR_SWITCH_MODE_WORD    = 8'h00;
   localparam logic [7:0]  ADR_THRESH     = 8'h04;
   localparam logic [7:0]  ADR_LOW_LIM    = 8'h08;
   localparam logic [7:0]  ADR_UP_LIM     = 8'h0c;
   localparam logic [7:0]  ADR_ZWAIT      = 8'h10;
   localparam logic [7:0]  ADR_DRV_STAT   = 8'h14;
   localparam logic [7:0]  ADR_RAMP_STAT  = 8'h18;
   localparam logic [7:0]  ADR_IRQ_STAT   = 8'h1c;
   localparam logic [7:0]  ADR_IRQ_EN     = 8'h20;
   localparam logic [7:0]  ADR_IRQ_CLR    = 8'h24;
   localparam logic [7:0]  ADR_PERIOD     = 8'h28;
   // Switch mode word fields
   localparam int          SWM_STOP_BIT   = 0;
   localparam int          SWM_FILT_BIT   = 1;
   // Driver status word fields
   localparam int          DRV_LOAD_LSB   = 0;
   localparam int          DRV_STALL_BIT  = 24;
   // Ramp status word fields
   localparam int          RS_EVENT_BIT   = 0;
   localparam int          RS_VZERO_BIT   = 1;
   localparam int          RS_WAIT_BIT    = 2;
   // Interrupt bits
   localparam int          IRQ_STALL_BIT  = 0;
   localparam int          IRQ_STEP_BIT   = 1;
   localparam int          IRQ_W          = 2;
   localparam int          LOAD_W         = 10;
   localparam int          THR_W          = 7;
   localparam int          PER_W          = 20;
   localparam int          ZW_W           = 16;
   localparam logic [PER_W-1:0] RST_UP_LIM  = 20'h00000;
   localparam logic [PER_W-1:0] RST_LOW_LIM = 20'h00000;
   localparam logic [ZW_W-1:0]  RST_ZWAIT   = 16'h0000;
   localparam logic [THR_W-1:0] RST_THRESH  = 7'h00;
   // Zero wait unit: 512 clocks per count
   localparam int          ZW_UNIT_NS     = 12800;
   localparam int          CLK_NS         = 25;
   localparam int          ZW_UNIT_CYC    = ZW_UNIT_NS / CLK_NS;
   localparam int          ZW_PRE_W       = 9;
   localparam int          FILT_N         = 4;
   typedef enum logic [1:0] {
      SDST_RUN  = 2'b00,
      SDST_STOP = 2'b01,
      SDST_WAIT = 2'b11
   } sdst_state_t;
endpackage : sdst_pkg

// *** sdst_filter.sv ***
// Averaging filter over four per-step load measurements.
// Assumes one-cycle sample strobes from the same clock domain.
`timescale 1ns/1ps
module sdst_filter (
   input  wire logic                             clk_sys,
   input  wire logic                             arst_n,
   input  wire logic                             smp_vld,
   input  wire logic [sdst_pkg::LOAD_W-1:0]      smp,
   input  wire logic                             filt_en,
   output logic                                  out_vld,
   output logic      [sdst_pkg::LOAD_W-1:0]      out_load
);
   logic [sdst_pkg::LOAD_W+1:0] acc_r;
   logic [1:0]                  cnt_r;
   logic [sdst_pkg::LOAD_W+1:0] sum_nxt;

   assign sum_nxt = acc_r + {2'b00, smp};

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         acc_r    <= '0;
         cnt_r    <= 2'h0;
         out_vld  <= 1'b0;
         out_load <= '0;
      end else begin
         out_vld <= 1'b0;
         if (!filt_en) begin
            acc_r <= '0;
            cnt_r <= 2'h0;
            if (smp_vld) begin
               out_vld  <= 1'b1;
               out_load <= smp;
            end
         end else if (smp_vld) begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'(sdst_pkg::FILT_N - 1)) begin
               acc_r    <= '0;
               out_vld  <= 1'b1;
               out_load <= sum_nxt[sdst_pkg::LOAD_W+1:2];
            end else begin
               acc_r <= sum_nxt;
            end
         end
      end
   end
endmodule : sdst_filter

// *** sdst_motor_model.sv ***
// Motor and power stage model: one full step per call of step().
// Assumes the caller enters step() right after a rising clock edge.
`timescale 1ns/1ps
module sdst_motor_model (
   input  wire logic                        clk_sys,
   output logic                             fullstep_tgl,
   output logic [sdst_pkg::LOAD_W-1:0]      raw_load
);
   initial begin
      fullstep_tgl = 1'b0;
      raw_load     = 10'h000;
   end

   task automatic step(input logic [sdst_pkg::LOAD_W-1:0] ld);
      raw_load <= ld;
      repeat (3) @(posedge clk_sys);
      fullstep_tgl <= ~fullstep_tgl;
      repeat (10) @(posedge clk_sys);
      // Sample window over, line drifts away
      raw_load <= ~ld;
      repeat (30) @(posedge clk_sys);
   endtask : step
endmodule : sdst_motor_model

// *** stall_detect_stop_on_stall_tb_top.sv ***
// Self-checking bench of the stall detect block, random loads and offsets.
// Assumes sdst_pkg and the motor model are compiled before it.
`timescale 1ns/1ps
module stall_detect_stop_on_stall_tb_top;
   localparam logic [7:0] ZADR [9] = '{sdst_pkg::ADR_SWITCH_MODE_WORD, sdst_pkg::ADR_THRESH,
      sdst_pkg::ADR_LOW_LIM, sdst_pkg::ADR_UP_LIM, sdst_pkg::ADR_ZWAIT, sdst_pkg::ADR_IRQ_STAT,
      sdst_pkg::ADR_IRQ_EN, sdst_pkg::ADR_RAMP_STAT, 8'hfc};
   localparam logic [7:0]  RADR [3] = '{sdst_pkg::ADR_THRESH, sdst_pkg::ADR_ZWAIT,
      sdst_pkg::ADR_UP_LIM};
   localparam logic [31:0] RMSK [3] = '{32'h0000007f, 32'h0000ffff, 32'h000fffff};
   logic        rnd_we;
   logic [3:0]  wsel;
   logic [31:0] wdat;
   logic [31:0] shadow [3];
   logic        clk_sys, arst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic        fullstep_tgl, ramp_halt, irq;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, ramp_velocity, actual_velocity, rd;
   logic [9:0]  raw_load, prev;
   logic [9:0]  ld [4];
   logic [6:0]  off;
   logic [11:0] sum;
   int          num_errors, checks_done, n, r;

   sdst_core sdst_core_i (.clk_sys(clk_sys), .arst_n(arst_n), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .fullstep_tgl(fullstep_tgl), .raw_load(raw_load), .ramp_velocity(ramp_velocity),
      .actual_velocity(actual_velocity), .ramp_halt(ramp_halt), .irq(irq));
   sdst_motor_model sdst_motor_model_i (.clk_sys(clk_sys), .fullstep_tgl(fullstep_tgl),
      .raw_load(raw_load));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= wsel;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1) break;
      end
      if (i == 50) begin
         check("bus answer", 32'h0, 32'h1);
         give_verdict();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
      wb(1'b0, adr, 32'h0);
      check(what, rd, exp);
   endtask : rdchk

   function automatic logic [9:0] exp_load(input logic [9:0] r, input logic [6:0] o);
      int s;
      s = int'(r) + int'(signed'(o));
      if (s < 0) s = 0;
      if (s > 1023) s = 1023;
      return s[9:0];
   endfunction : exp_load

   initial begin
      arst_n = 1'b0;
      {wb_we_i, wb_cyc_i, wb_stb_i} = 3'b000;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      wsel = 4'hf;
      ramp_velocity = 32'h0;
      void'($urandom(32'h4cbf));
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      rdchk(sdst_pkg::ADR_DRV_STAT, 32'h3ff, "load after reset");
      foreach (ZADR[k]) rdchk(ZADR[k], 32'h0, "reset or unmapped");
      wb(1'b1, sdst_pkg::ADR_LOW_LIM, 32'h000fffff);
      // Random loads and offsets, clamp corners first
      for (int i = 0; i < 10; i++) begin
         off = (i == 0) ? 7'h40 : (i == 1) ? 7'h3f : 7'($urandom);
         ld[0] = (i == 0) ? 10'h020 : (i == 1) ? 10'h3f0 : 10'($urandom);
         ramp_velocity <= $urandom;
         wb(1'b1, sdst_pkg::ADR_THRESH, {25'h0, off});
         sdst_motor_model_i.step(ld[0]);
         rdchk(sdst_pkg::ADR_DRV_STAT, {22'h0, exp_load(ld[0], off)}, "load");
         check("velocity passed", actual_velocity, ramp_velocity);
      end
      prev = exp_load(ld[0], off);
      wb(1'b1, sdst_pkg::ADR_THRESH, 32'h0);
      wb(1'b1, sdst_pkg::ADR_IRQ_CLR, 32'h3);
      wb(1'b1, sdst_pkg::ADR_SWITCH_MODE_WORD, 32'h2);
      sum = 12'h0;
      for (int k = 0; k < 4; k++) begin
         ld[k] = 10'($urandom);
         sum = sum + {2'b00, ld[k]};
         sdst_motor_model_i.step(ld[k]);
         rdchk(sdst_pkg::ADR_DRV_STAT, {22'h0, (k == 3) ? sum[11:2] : prev}, "filtered");
      end
      check("irq masked", {31'h0, irq}, 32'h0);
      rdchk(sdst_pkg::ADR_IRQ_STAT, 32'h2, "irq status");
      wb(1'b1, sdst_pkg::ADR_IRQ_EN, 32'h2);
      repeat (2) @(posedge clk_sys);
      check("irq raised", {31'h0, irq}, 32'h1);
      wb(1'b1, sdst_pkg::ADR_IRQ_CLR, 32'h2);
      repeat (2) @(posedge clk_sys);
      check("irq cleared", {31'h0, irq}, 32'h0);
      // Stall with stop enabled, released by the status read
      wb(1'b1, sdst_pkg::ADR_IRQ_EN, 32'h1);
      wb(1'b1, sdst_pkg::ADR_ZWAIT, 32'h1);
      wb(1'b1, sdst_pkg::ADR_SWITCH_MODE_WORD, 32'h1);
      ramp_velocity <= $urandom | 32'h1;
      sdst_motor_model_i.step(10'h000);
      check("halt", {31'h0, ramp_halt}, 32'h1);
      check("velocity forced", actual_velocity, 32'h0);
      check("stall irq", {31'h0, irq}, 32'h1);
      rdchk(sdst_pkg::ADR_DRV_STAT, 32'h01000000, "indicator");
      rdchk(sdst_pkg::ADR_RAMP_STAT, 32'h3, "ramp status");
      rdchk(sdst_pkg::ADR_RAMP_STAT, 32'h6, "waiting");
      for (n = 0; n < 3000 && ramp_halt !== 1'b0; n++) @(posedge clk_sys);
      check("zero wait", {31'h0, (n > 500 && n < 1100)}, 32'h1);
      @(posedge clk_sys);
      check("restart", actual_velocity, ramp_velocity);
      sdst_motor_model_i.step(10'h000);
      check("halt again", {31'h0, ramp_halt}, 32'h1);
      ramp_velocity <= 32'h0;
      wb(1'b1, sdst_pkg::ADR_SWITCH_MODE_WORD, 32'h0);
      repeat (2) @(posedge clk_sys);
      check("release by disable", {31'h0, ramp_halt}, 32'h0);
      // Velocity window: below lower, above upper, then inside
      wb(1'b1, sdst_pkg::ADR_SWITCH_MODE_WORD, 32'h1);
      wb(1'b1, sdst_pkg::ADR_LOW_LIM, 32'h10);
      sdst_motor_model_i.step(10'h100);
      sdst_motor_model_i.step(10'h000);
      check("below lower", {31'h0, ramp_halt}, 32'h0);
      wb(1'b1, sdst_pkg::ADR_LOW_LIM, 32'hfffff);
      wb(1'b1, sdst_pkg::ADR_UP_LIM, 32'h400);
      sdst_motor_model_i.step(10'h100);
      sdst_motor_model_i.step(10'h000);
      check("above upper", {31'h0, ramp_halt}, 32'h0);
      wb(1'b1, sdst_pkg::ADR_UP_LIM, 32'h10);
      sdst_motor_model_i.step(10'h100);
      sdst_motor_model_i.step(10'h000);
      check("inside window", {31'h0, ramp_halt}, 32'h1);
      wb(1'b1, sdst_pkg::ADR_SWITCH_MODE_WORD, 32'h0);
      // Mid-run reset, registers back to reset values
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("irq in reset", {31'h0, irq}, 32'h0);
      check("halt in reset", {31'h0, ramp_halt}, 32'h0);
      arst_n <= 1'b1;
      rdchk(sdst_pkg::ADR_DRV_STAT, 32'h3ff, "load after reset");
      foreach (ZADR[k]) rdchk(ZADR[k], 32'h0, "reset again");
      // Random accesses; writes without full select are ignored
      shadow = '{32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 12; i++) begin
         r = $urandom_range(2);
         wsel = (i < 4) ? (4'hf ^ (4'h1 << i)) : 4'($urandom);
         rnd_we = (i < 4) ? 1'b1 : 1'($urandom);
         wdat = $urandom;
         wb(rnd_we, RADR[r], wdat);
         if (rnd_we && wsel == 4'hf) shadow[r] = wdat & RMSK[r];
         wsel = 4'hf;
         rdchk(RADR[r], shadow[r], "register");
      end
      give_verdict();
   end
endmodule : stall_detect_stop_on_stall_tb_top
